/* rtl/pll_scan_pkg.sv */
package pll_scan_pkg;
	localparam int CHAIN_BITS = 144;
	localparam int NUM_OUT = 5;
	localparam int NUM_GROUPS = 7;
	localparam int GROUP_BITS = 18;
	localparam int COUNT_W = 8;
	localparam int RATIO_W = 9;
	localparam int BIT_CNT_W = 8;
	// Field positions inside one divider group.
	localparam int LOW_LSB = 0;
	localparam int BYPASS_BIT = 8;
	localparam int HIGH_LSB = 9;
	localparam int ODD_BIT = 17;
	// Group order in the chain, counted from the first bit shifted in.
	localparam int M_GRP = 5;
	localparam int N_GRP = 6;
	// Bandwidth fields after the seven divider groups.
	localparam int PUMP_LSB = 126;
	localparam int PUMP_W = 3;
	localparam int FILT_LSB = 135;
	localparam int RES_W = 5;
	localparam int CAP_LSB = 140;
	localparam int CAP_W = 2;
	// Timing at 125 MHz.
	localparam int CLK_MHZ = 125;
	localparam int SCAN_HALF_CYC = 2;
	localparam int UPDATE_NS = 40;
	localparam int UPDATE_CYC = (UPDATE_NS * CLK_MHZ + 999) / 1000;
	localparam int ARESET_NS = 100;
	localparam int ARESET_CYC = (ARESET_NS * CLK_MHZ + 999) / 1000;
	localparam int LOCK_NS = 800;
	localparam int LOCK_CYC = (LOCK_NS * CLK_MHZ + 999) / 1000;
	localparam int TIMER_W = 8;
	typedef enum logic [3:0] {
		CT_IDLE = 4'h0,
		CT_ARM = 4'h1,
		CT_GATE = 4'h2,
		CT_SHIFT = 4'h3,
		CT_RELEASE = 4'h4,
		CT_APPLY = 4'h5,
		CT_WAIT_HI = 4'h6,
		CT_WAIT_LO = 4'h7,
		CT_RESET = 4'h8
	} ctrl_state_t;
endpackage : pll_scan_pkg

/* rtl/pll_scan_if.sv */
`timescale 1ns/1ps
interface pll_scan_if;
	logic scan_clk;
	logic scan_clk_ena;
	logic scan_data;
	logic config_update;
	logic scan_done;
	logic areset;
	modport ctrl (
		output scan_clk, scan_clk_ena, scan_data, config_update, areset,
		input scan_done
	);
	modport pll (
		input scan_clk, scan_clk_ena, scan_data, config_update, areset,
		output scan_done
	);
endinterface : pll_scan_if

/* rtl/pll_scan_ctrl.sv */
`timescale 1ns/1ps
module pll_scan_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [pll_scan_pkg::CHAIN_BITS-1:0] image,
	output logic busy,
	output logic done_q,
	pll_scan_if.ctrl link
);
	import pll_scan_pkg::*;

	ctrl_state_t state_q;
	logic [1:0] half_q;
	logic sclk_q;
	logic fall;
	logic gate_q;
	logic data_q;
	logic upd_q;
	logic areset_q;
	logic [CHAIN_BITS-1:0] sh_q;
	logic [BIT_CNT_W-1:0] bits_q;
	logic [TIMER_W-1:0] timer_q;

	////////////////////////////////////////////////////////////////////////////////
	// The scan clock is made here by division, so it shares our clock domain.
	assign fall = sclk_q && (half_q == 2'(SCAN_HALF_CYC - 1));
	assign busy = (state_q != CT_IDLE);
	assign link.scan_clk = sclk_q;
	assign link.scan_clk_ena = gate_q;
	assign link.scan_data = data_q;
	assign link.config_update = upd_q;
	assign link.areset = areset_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			half_q <= 2'h0;
			sclk_q <= 1'b0;
		end else if (half_q == 2'(SCAN_HALF_CYC - 1)) begin
			half_q <= 2'h0;
			sclk_q <= ~sclk_q;
		end else begin
			half_q <= half_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gate, data and apply outputs change only with the falling scan edge, half a period clear of capture; areset does not.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= CT_IDLE;
			gate_q <= 1'b0;
			data_q <= 1'b0;
			upd_q <= 1'b0;
			areset_q <= 1'b0;
			done_q <= 1'b0;
			sh_q <= '0;
			bits_q <= '0;
			timer_q <= '0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				CT_IDLE: begin
					if (start) begin
						sh_q <= image;
						state_q <= CT_ARM;
					end
				end
				CT_ARM: begin
					if (fall) begin
						gate_q <= 1'b1;
						state_q <= CT_GATE;
					end
				end
				CT_GATE: begin
					if (fall) begin
						data_q <= sh_q[0];
						sh_q <= sh_q >> 1;
						bits_q <= '0;
						state_q <= CT_SHIFT;
					end
				end
				CT_SHIFT: begin
					if (fall) begin
						if (bits_q == BIT_CNT_W'(CHAIN_BITS - 1)) begin
							gate_q <= 1'b0;
							data_q <= 1'b0;
							state_q <= CT_RELEASE;
						end else begin
							data_q <= sh_q[0];
							sh_q <= sh_q >> 1;
							bits_q <= bits_q + BIT_CNT_W'(1);
						end
					end
				end
				CT_RELEASE: begin
					if (fall) begin
						upd_q <= 1'b1;
						state_q <= CT_APPLY;
					end
				end
				CT_APPLY: begin
					if (fall) begin
						upd_q <= 1'b0;
						state_q <= CT_WAIT_HI;
					end
				end
				CT_WAIT_HI: begin
					if (link.scan_done) begin
						state_q <= CT_WAIT_LO;
					end
				end
				CT_WAIT_LO: begin
					if (!link.scan_done) begin
						areset_q <= 1'b1;
						timer_q <= TIMER_W'(ARESET_CYC - 1);
						state_q <= CT_RESET;
					end
				end
				CT_RESET: begin
					// The completion flag is already low for the next pass, since CT_WAIT_LO waited for it to fall.
					if (timer_q == '0) begin
						areset_q <= 1'b0;
						done_q <= 1'b1;
						state_q <= CT_IDLE;
					end else begin
						timer_q <= timer_q - TIMER_W'(1);
					end
				end
				default: begin
					state_q <= CT_IDLE;
				end
			endcase
		end
	end
endmodule : pll_scan_ctrl

/* rtl/pll_scan_device.sv */
`timescale 1ns/1ps
module pll_scan_device (
	input wire logic clk,
	input wire logic rst_n,
	pll_scan_if.pll link,
	output logic [pll_scan_pkg::NUM_OUT-1:0] out_clk,
	output logic [pll_scan_pkg::CHAIN_BITS-1:0] active_q,
	output logic [pll_scan_pkg::PUMP_W-1:0] pump_current_code,
	output logic [pll_scan_pkg::RES_W-1:0] filter_resistor_code,
	output logic [pll_scan_pkg::CAP_W-1:0] filter_capacitor_code,
	output logic bandwidth_valid_q,
	output logic locked_q
);
	import pll_scan_pkg::*;

	logic sclk_prev_q;
	logic rise;
	logic armed_q;
	logic [CHAIN_BITS-1:0] chain_q;
	logic done_q;
	logic [TIMER_W-1:0] upd_q;
	logic [TIMER_W-1:0] lock_q;
	logic pump_ok;
	logic res_ok;
	logic cap_ok;

	////////////////////////////////////////////////////////////////////////////////
	// The scan clock comes from logic on our own clock, so only its edge is detected.
	assign rise = link.scan_clk && !sclk_prev_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= link.scan_clk;
		end
	end

	// The first rising edge with the gate high only arms the chain.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
		end else if (rise) begin
			armed_q <= link.scan_clk_ena;
		end
	end

	// New bits enter at the top, so the first bit ends at index 0.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_q <= '0;
		end else if (rise && link.scan_clk_ena && armed_q) begin
			chain_q <= {link.scan_data, chain_q[CHAIN_BITS-1:1]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Apply wins over a simultaneous reset so that an update is never lost.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			upd_q <= '0;
			active_q <= '0;
		end else if (rise && link.config_update && !done_q) begin
			done_q <= 1'b1;
			upd_q <= TIMER_W'(UPDATE_CYC - 1);
		end else if (done_q && upd_q != '0) begin
			upd_q <= upd_q - TIMER_W'(1);
		end else if (done_q) begin
			active_q <= chain_q;
			done_q <= 1'b0;
		end else if (link.areset) begin
			done_q <= 1'b0;
		end
	end

	assign link.scan_done = done_q;

	// Lock restarts after every reset pulse and after every update.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_q <= '0;
			locked_q <= 1'b0;
		end else if (link.areset || done_q) begin
			lock_q <= '0;
			locked_q <= 1'b0;
		end else if (lock_q == TIMER_W'(LOCK_CYC - 1)) begin
			locked_q <= 1'b1;
		end else begin
			lock_q <= lock_q + TIMER_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign pump_current_code = active_q[PUMP_LSB +: PUMP_W];
	assign filter_resistor_code = active_q[FILT_LSB +: RES_W];
	assign filter_capacitor_code = active_q[CAP_LSB +: CAP_W];

	always_comb begin
		pump_ok = (pump_current_code == 3'h0) || (pump_current_code == 3'h1) ||
			(pump_current_code == 3'h3) || (pump_current_code == 3'h7);
		case (filter_resistor_code)
			5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13: res_ok = 1'b1;
			5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E: res_ok = 1'b1;
			default: res_ok = 1'b0;
		endcase
		cap_ok = (filter_capacitor_code != 2'h2);
	end

	// Out-of-table codes are still loaded; this flag only reports them.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bandwidth_valid_q <= 1'b1;
		end else begin
			bandwidth_valid_q <= pump_ok && res_ok && cap_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output dividers, with the core clock standing in for the oscillator.
	for (genvar k = 0; k < NUM_OUT; k++) begin : g_div
		localparam int BASE = (NUM_OUT - 1 - k) * GROUP_BITS;
		logic [COUNT_W-1:0] hi;
		logic [COUNT_W-1:0] lo;
		logic byp;
		logic odd;
		logic [RATIO_W-1:0] ratio;
		logic [RATIO_W-1:0] cnt_q;
		logic [RATIO_W-1:0] cnt_d;
		logic high_q;
		logic fall_q;

		assign hi = active_q[BASE + HIGH_LSB +: COUNT_W];
		assign lo = active_q[BASE + LOW_LSB +: COUNT_W];
		assign byp = active_q[BASE + BYPASS_BIT];
		assign odd = active_q[BASE + ODD_BIT];
		assign ratio = {1'b0, hi} + {1'b0, lo};
		assign cnt_d = (cnt_q + RATIO_W'(1) >= ratio) ? '0 : cnt_q + RATIO_W'(1);

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q <= '0;
				high_q <= 1'b0;
			end else begin
				cnt_q <= cnt_d;
				high_q <= (cnt_d < {1'b0, hi});
			end
		end

		// Marks the last high cycle so odd mode can drop half a cycle early.
		always_ff @(negedge clk or negedge rst_n) begin
			if (!rst_n) begin
				fall_q <= 1'b0;
			end else begin
				fall_q <= high_q && (cnt_q + RATIO_W'(1) == {1'b0, hi});
			end
		end

		// Bypass ignores every other field of the group, at the cost of a gated clock path.
		assign out_clk[k] = byp ? clk : (high_q && !(odd && fall_q));
	end
endmodule : pll_scan_device

/* dv/pll_scan_properties.sv */
`timescale 1ns/1ps
module pll_scan_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scan_clk,
	input wire logic scan_clk_ena,
	input wire logic scan_data,
	input wire logic config_update,
	input wire logic scan_done,
	input wire logic areset
);
	logic sc_q;
	logic [7:0] rise_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Counts scan rises seen with the gate up; the first one only arms the chain.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sc_q <= 1'b0;
			rise_q <= 8'h00;
		end else begin
			sc_q <= scan_clk;
			if (!scan_clk_ena)
				rise_q <= 8'h00;
			else if (scan_clk && !sc_q)
				rise_q <= rise_q + 8'h01;
		end
	end
	////////////////////////////////////////
	bit_count_a: assert property ($fell(scan_clk_ena) |-> rise_q == 8'h91)
		else $error("gate held for wrong number of rises");
	apply_width_a: assert property ($rose(config_update) |-> config_update[*4] ##1 !config_update)
		else $error("apply pulse not one scan period");
	apply_taken_a: assert property ($rose(scan_clk) && config_update && !scan_done |=> scan_done)
		else $error("apply not answered");
	done_len_a: assert property ($rose(scan_done) && !areset |-> scan_done[*5] ##1 !scan_done)
		else $error("completion flag length wrong");
	data_edge_a: assert property ($changed(scan_data) |-> $fell(scan_clk))
		else $error("data moved off the falling scan edge");
	gate_edge_a: assert property ($changed(scan_clk_ena) |-> $fell(scan_clk))
		else $error("gate moved off the falling scan edge");
	no_apply_a: assert property (scan_clk_ena |-> !config_update)
		else $error("apply while shifting");
	reset_after_a: assert property ($fell(scan_done) |-> ##[1:8] areset)
		else $error("no reset after update");
	reset_width_a: assert property ($rose(areset) |-> areset[*8] ##1 areset[*5] ##1 !areset)
		else $error("reset width wrong");
	done_clear_a: assert property (areset && !($rose(scan_clk) && config_update) |=> !scan_done)
		else $error("reset left completion flag high");
endmodule : pll_scan_properties

/* dv/pll_scan_chain_reconfig_tb.sv */
`timescale 1ns/1ps
module pll_scan_chain_reconfig_tb;
	import pll_scan_pkg::*;
	logic clk;
	logic rst_n;
	logic start;
	logic busy;
	logic done_q;
	logic armed;
	logic sc_q;
	logic bandwidth_valid_q;
	logic locked_q;
	logic [CHAIN_BITS-1:0] image;
	logic [CHAIN_BITS-1:0] img;
	logic [CHAIN_BITS-1:0] last;
	logic [CHAIN_BITS-1:0] shadow;
	logic [CHAIN_BITS-1:0] active_q;
	logic [NUM_OUT-1:0] out_clk;
	logic [PUMP_W-1:0] pump_current_code;
	logic [RES_W-1:0] filter_resistor_code;
	logic [CAP_W-1:0] filter_capacitor_code;
	logic [4:0] res_tab [11] = '{5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14, 5'h18,
		5'h1B, 5'h1C, 5'h1E};
	logic [2:0] pump_tab [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
	logic [1:0] cap_tab [3] = '{2'h0, 2'h1, 2'h3};
	int errors;
	int n_compared;
	int edges [5];
	pll_scan_if link ();
	pll_scan_ctrl pll_scan_ctrl_inst (.clk(clk), .rst_n(rst_n), .start(start), .image(image),
		.busy(busy), .done_q(done_q), .link(link.ctrl));
	pll_scan_device pll_scan_device_inst (.clk(clk), .rst_n(rst_n), .link(link.pll),
		.out_clk(out_clk), .active_q(active_q), .pump_current_code(pump_current_code),
		.filter_resistor_code(filter_resistor_code),
		.filter_capacitor_code(filter_capacitor_code),
		.bandwidth_valid_q(bandwidth_valid_q), .locked_q(locked_q));
	pll_scan_properties pll_scan_properties_inst (.clk(clk), .rst_n(rst_n),
		.scan_clk(link.scan_clk), .scan_clk_ena(link.scan_clk_ena), .scan_data(link.scan_data),
		.config_update(link.config_update), .scan_done(link.scan_done), .areset(link.areset));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////
	// Rebuilds the chain from the wire alone, so bit order is judged apart from the device.
	always @(posedge clk) begin
		sc_q <= link.scan_clk;
		if (link.scan_clk && !sc_q && link.scan_clk_ena) begin
			if (armed)
				shadow <= {link.scan_data, shadow[CHAIN_BITS-1:1]};
			armed <= 1'b1;
		end else if (!link.scan_clk_ena)
			armed <= 1'b0;
	end
	always @(posedge out_clk[0]) edges[0] = edges[0] + 1;
	always @(posedge out_clk[1]) edges[1] = edges[1] + 1;
	always @(posedge out_clk[2]) edges[2] = edges[2] + 1;
	always @(posedge out_clk[3]) edges[3] = edges[3] + 1;
	always @(posedge out_clk[4]) edges[4] = edges[4] + 1;
	function automatic logic [17:0] grp(input logic odd, input logic [7:0] hi,
		input logic byp, input logic [7:0] lo);
		return {odd, hi, byp, lo};
	endfunction : grp
	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [CHAIN_BITS-1:0] got, input logic [CHAIN_BITS-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic run(input logic [CHAIN_BITS-1:0] im, input logic valid);
		int i;
		image = im;
		start = 1'b1;
		tick();
		start = 1'b0;
		for (i = 0; i < 2000 && done_q !== 1'b1; i++) begin
			tick();
			if (i == 100) begin
				check(active_q, last);
				check(busy, 1'b1);
			end
		end
		if (done_q !== 1'b1) begin
			errors++;
			print_verdict();
		end
		check(shadow, im);
		check(busy, 1'b0);
		check(active_q, im);
		check(pump_current_code, im[128:126]);
		check(filter_resistor_code, im[139:135]);
		check(filter_capacitor_code, im[141:140]);
		check(bandwidth_valid_q, valid);
		check(locked_q, 1'b0);
		repeat (LOCK_CYC + 4) tick();
		check(locked_q, 1'b1);
		last = im;
	endtask : run
	// Fixed window of 200 clocks; ratios 5 and 1 give exact counts, ratio 3 may straddle.
	task automatic measure(input int e0);
		edges = '{default: 0};
		repeat (200) tick();
		check(edges[0], e0);
		check(edges[1], 200);
		check(edges[2] inside {66, 67}, 1'b1);
		check(edges[3], 100);
		check(edges[4], 100);
	endtask : measure
	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		image = '0;
		armed = 1'b0;
		sc_q = 1'b0;
		last = '0;
		errors = 0;
		n_compared = 0;
		repeat (10) tick();
		rst_n = 1'b1;
		img = {2'h0, 2'h3, 5'h13, 6'h00, 3'h3, grp(1'b0, 8'h00, 1'b1, 8'h00),
			grp(1'b0, 8'h04, 1'b0, 8'h04), grp(1'b0, 8'h02, 1'b0, 8'h03),
			grp(1'b0, 8'h00, 1'b1, 8'h55), grp(1'b1, 8'h02, 1'b0, 8'h01),
			grp(1'b0, 8'h01, 1'b0, 8'h01), grp(1'b0, 8'h01, 1'b0, 8'h01)};
		run(img, 1'b1);
		measure(40);
		for (int k = 0; k < 11; k++) begin
			img[139:135] = res_tab[k];
			img[128:126] = pump_tab[k % 4];
			img[141:140] = cap_tab[k % 3];
			run(img, 1'b1);
		end
		img[128:126] = 3'h2;
		img[89:72] = grp(1'b0, 8'h00, 1'b1, 8'h00);
		run(img, 1'b0);
		measure(200);
		print_verdict();
	end
endmodule : pll_scan_chain_reconfig_tb
